// File: logic/frr_ctrl.sv
// fault response and restart controller for the output stage
// assumes fault_i and command inputs are synchronous to clk_sys_i
// and unit_tick_i is the one-cycle delay-unit pulse from the unit setting
//
// Overview of operation
// - code 00 ignores the fault and leaves the output running.
// - code 01 keeps running for the delay, then shuts down and follows the retry field if still faulty.
// - code 10 disables the output at once, then follows the retry field.
// - code 11 holds the output off while the fault lasts, then resumes.
// - any of status clear, clear-faults, reset, off-on, bias loss clears.
// - retry code 000 keeps the output off until the fault is cleared.
// - retry codes 1 to 6 give that many attempts, then stay off latched.
// - attempt starts are spaced by 2 to the delay field value times the delay unit.
// - retry code 111 restarts without any limit.
// - the retry count sits in bits 5:3 of the response setting.
// - delay field value n means 2 to the n delay units, 1 to 128.
// - endless retrying stops on off command, bias loss or another fault.
`timescale 1ns/1ps
`default_nettype none
module frr_ctrl (
  // clock and reset (reset models bias power)
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // response setting access
  input wire logic cfg_we_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // fault and clear sources
  input wire logic fault_i,
  input wire logic other_shutdown_i,
  input wire logic status_clear_i,
  input wire logic clear_faults_i,
  input wire logic reset_cmd_i,
  input wire logic output_cmd_on_i,
  input wire logic unit_tick_i,
  // output control and status
  output logic output_enable_o,
  output logic fault_latched_o,
  output logic [2:0] attempts_o
);

  frr_pkg::frr_state_t state;
  frr_pkg::frr_state_t next_state;
  logic [7:0] reaction;
  logic [2:0] attempts;
  logic [2:0] next_attempts;
  logic latched;
  logic cmd_on_q;
  logic timer_start;
  logic timer_done;
  logic fault_cleared;
  logic off_cmd;
  logic [1:0] resp;
  logic [2:0] retry;
  logic [2:0] delay_code;
  logic retries_left;
  logic next_runs;
  logic next_latched;

  // ---------------------------------------------
  // field decode
  // ---------------------------------------------
  assign resp = reaction[frr_pkg::RESP_MSB:frr_pkg::RESP_LSB];
  assign retry = reaction[frr_pkg::RETRY_MSB:frr_pkg::RETRY_LSB];
  assign delay_code = reaction[frr_pkg::DELAY_MSB:frr_pkg::DELAY_LSB];
  // endless retry or attempts still owed
  assign retries_left = (retry == frr_pkg::RETRY_FOREVER) ||
    (attempts < retry);
  // off command: on level falling
  assign off_cmd = cmd_on_q && !output_cmd_on_i;
  // any clear source, off-then-on seen as the off edge
  assign fault_cleared = status_clear_i || clear_faults_i ||
    reset_cmd_i || off_cmd;

  // ---------------------------------------------
  // register and status outputs
  // ---------------------------------------------
  assign cfg_rdata_o = reaction;
  assign fault_latched_o = latched;
  assign attempts_o = attempts;

  // response setting storage
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reaction <= frr_pkg::REACTION_RESET;
    end else if (cfg_we_i) begin
      reaction <= cfg_wdata_i;
    end
  end

  // ---------------------------------------------
  // delay timer for grace and retry spacing
  // ---------------------------------------------
  frr_delay_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .start_i(timer_start),
    .unit_tick_i(unit_tick_i),
    .delay_code_i(delay_code),
    .done_o(timer_done)
  );

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    next_state = state;
    next_attempts = attempts;
    timer_start = 1'b0;
    unique case (state)
      frr_pkg::FRR_ON: begin
        if (fault_i && output_cmd_on_i) begin
          unique case (resp)
            frr_pkg::RESP_IGNORE: next_state = frr_pkg::FRR_ON;
            frr_pkg::RESP_RUN_DELAY: begin
              next_state = frr_pkg::FRR_GRACE;
              timer_start = 1'b1;
            end
            frr_pkg::RESP_SHUTDOWN: begin
              next_state = frr_pkg::FRR_OFF_WAIT;
            end
            frr_pkg::RESP_WAIT_CLEAR: begin
              next_state = frr_pkg::FRR_HOLD_OFF;
            end
          endcase
        end
      end
      frr_pkg::FRR_GRACE: begin
        if (!fault_i) begin
          next_state = frr_pkg::FRR_ON;
        end else if (timer_done) begin
          next_state = frr_pkg::FRR_OFF_WAIT;
        end
      end
      frr_pkg::FRR_OFF_WAIT: begin
        // output is off; decide on retrying
        if (retry == frr_pkg::RETRY_NONE || !retries_left) begin
          next_state = frr_pkg::FRR_LATCHED;
        end else begin
          next_state = frr_pkg::FRR_RETRY_WAIT;
          timer_start = 1'b1;
        end
      end
      frr_pkg::FRR_RETRY_WAIT: begin
        if (timer_done) begin
          next_state = frr_pkg::FRR_ON;
          if (retry != frr_pkg::RETRY_FOREVER) begin
            next_attempts = attempts + 3'h1;
          end
        end
      end
      frr_pkg::FRR_HOLD_OFF: begin
        if (!fault_i) begin
          next_state = frr_pkg::FRR_ON;
        end
      end
      frr_pkg::FRR_LATCHED: begin
        next_state = frr_pkg::FRR_LATCHED;
      end
      default: next_state = frr_pkg::FRR_LATCHED;
    endcase
    // other shutdown overrides everything, then off command and clears
    if (other_shutdown_i) begin
      next_state = frr_pkg::FRR_LATCHED;
    end else if (fault_cleared) begin
      next_state = frr_pkg::FRR_ON;
      next_attempts = 3'h0;
    end
    // a clean run after a retry also refills the attempts
    if (state == frr_pkg::FRR_ON && !fault_i && !timer_start) begin
      next_attempts = 3'h0;
    end
  end

  // ---------------------------------------------
  // registered state
  // ---------------------------------------------
  // output runs only in the on and grace states, and only
  // while it is commanded on
  assign next_runs = output_cmd_on_i &&
    (next_state == frr_pkg::FRR_ON || next_state == frr_pkg::FRR_GRACE);
  // the flag shows the latched state from the same edge
  assign next_latched = (next_state == frr_pkg::FRR_LATCHED);

  // control state
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= frr_pkg::FRR_ON;
    end else begin
      state <= next_state;
    end
  end

  // restart attempts made since the last clear or clean run
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      attempts <= 3'h0;
    end else begin
      attempts <= next_attempts;
    end
  end

  // last on command; resets low so no false off edge follows reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_on_q <= 1'b0;
    end else begin
      cmd_on_q <= output_cmd_on_i;
    end
  end

  // ---------------------------------------------
  // output flags
  // ---------------------------------------------
  // latched fault flag, also cleared by reset as for bias loss
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latched <= 1'b0;
    end else begin
      latched <= next_latched;
    end
  end

  // output enable from a flip-flop, held low through reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      output_enable_o <= 1'b0;
    end else begin
      output_enable_o <= next_runs;
    end
  end

endmodule
`default_nettype wire

// File: logic/frr_pkg.sv
// package for the fault response and restart controller
// assumes a single 40 MHz system clock domain
package frr_pkg;

  // response setting field positions
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  // response setting reset value
  localparam logic [7:0] REACTION_RESET = 8'h80;

  // response codes
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_RUN_DELAY = 2'h1;
  localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
  localparam logic [1:0] RESP_WAIT_CLEAR = 2'h3;

  // retry codes
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // width of the delay unit counter
  localparam int UNIT_W = 8;
  localparam int SPAN_W = 8 + UNIT_W;

  // control states
  typedef enum logic [2:0] {
    FRR_ON,
    FRR_GRACE,
    FRR_OFF_WAIT,
    FRR_RETRY_WAIT,
    FRR_HOLD_OFF,
    FRR_LATCHED
  } frr_state_t;

endpackage

// File: logic/frr_delay_timer.sv
// delay timer: counts programmed delay units
// assumes unit_tick_i is a one-cycle enable pulse per delay unit
`timescale 1ns/1ps
`default_nettype none
module frr_delay_timer (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // control
  input wire logic start_i,
  input wire logic unit_tick_i,
  input wire logic [2:0] delay_code_i,
  // status
  output logic done_o
);

  logic [8:0] left;
  logic [8:0] span;

  // 2**code units, code 0..7 gives 1..128
  assign span = 9'h001 << delay_code_i;
  assign done_o = (left == 9'h001) && unit_tick_i;

  // -------------------------------------------
  // countdown
  // -------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      left <= 9'h000;
    end else if (start_i) begin
      left <= span;
    end else if (unit_tick_i && left != 9'h000) begin
      left <= left - 9'h001;
    end
  end

endmodule
`default_nettype wire

// File: sim/frr_ctrl_monitor.sv
// checker on the fault response controller ports
// assumes one clock domain, bound onto frr_ctrl
`timescale 1ns/1ps
`default_nettype none
module frr_ctrl_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // watched ports
  input wire logic cfg_we_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic fault_i,
  input wire logic other_shutdown_i,
  input wire logic status_clear_i,
  input wire logic clear_faults_i,
  input wire logic reset_cmd_i,
  input wire logic output_cmd_on_i,
  input wire logic output_enable_o,
  input wire logic fault_latched_o,
  input wire logic [2:0] attempts_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // quiet: no write, no forced shutdown, output commanded on
  wire q = !cfg_we_i && !other_shutdown_i && output_cmd_on_i;
  wire [1:0] rsp = cfg_rdata_o[7:6];
  // a clear that no forced shutdown overrides
  wire clr = !other_shutdown_i &&
    (clear_faults_i || status_clear_i || reset_cmd_i);
  a_ignore_stays_on: assert property (
    q && rsp == 2'h0 && output_enable_o |=> output_enable_o)
    else $error("ignore mode dropped output");
  a_shut_at_once: assert property (
    q && !clr && rsp == 2'h2 && fault_i && output_enable_o
    |=> !output_enable_o) else $error("no shutdown");
  a_hold_in_fault: assert property (
    q && !clr && rsp == 2'h3 && fault_i |=> !output_enable_o)
    else $error("on during fault");
  a_latch_is_off: assert property (
    fault_latched_o |-> !output_enable_o) else $error("latched but on");
  a_cfg_readback: assert property (
    cfg_we_i |=> cfg_rdata_o == $past(cfg_wdata_i)) else $error("readback");
  a_attempt_bound: assert property (
    cfg_rdata_o[5:3] != 3'h7 |-> attempts_o <= cfg_rdata_o[5:3])
    else $error("too many tries");
  a_clear_unlatch: assert property (
    clr |=> !fault_latched_o) else $error("clear ignored");
  a_clear_refill: assert property (
    clr |=> attempts_o == 3'h0) else $error("attempts kept");
  a_forever_open: assert property (
    q && cfg_rdata_o[5:3] == 3'h7 && !fault_latched_o |=> !fault_latched_o)
    else $error("gave up");
  a_shutdown_latch: assert property (
    other_shutdown_i |=> fault_latched_o && !output_enable_o)
    else $error("forced shutdown ignored");
endmodule
bind frr_ctrl frr_ctrl_monitor mon (
  .clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i),
  .cfg_we_i(cfg_we_i),
  .cfg_wdata_i(cfg_wdata_i),
  .cfg_rdata_o(cfg_rdata_o),
  .fault_i(fault_i),
  .other_shutdown_i(other_shutdown_i),
  .status_clear_i(status_clear_i),
  .clear_faults_i(clear_faults_i),
  .reset_cmd_i(reset_cmd_i),
  .output_cmd_on_i(output_cmd_on_i),
  .output_enable_o(output_enable_o),
  .fault_latched_o(fault_latched_o),
  .attempts_o(attempts_o)
);
`default_nettype wire

// File: sim/frr_host_model.sv
// host side model: setting writes and the delay unit time base
// assumes the bench calls wr just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module frr_host_model (
  // clock
  input wire logic clk_sys_i,
  // setting write and delay unit
  output logic cfg_we_o,
  output logic [7:0] cfg_wdata_o,
  output logic unit_tick_o
);
  logic [1:0] div = 2'h0;
  initial begin
    cfg_we_o = 1'b0;
    cfg_wdata_o = 8'h00;
  end
  // one delay unit every four clocks
  always @(posedge clk_sys_i) begin
    div <= div + 2'h1;
  end
  assign unit_tick_o = (div == 2'h3);
  // one-cycle write, data inverted once released
  task automatic wr(input logic [7:0] d);
    cfg_we_o = 1'b1;
    cfg_wdata_o = d;
    @(posedge clk_sys_i);
    #1;
    cfg_we_o = 1'b0;
    cfg_wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

// File: sim/test_frr_ctrl.sv
// bench for the fault response controller
// assumes the host model supplies writes and delay units
`timescale 1ns/1ps
`default_nettype none
module test_frr_ctrl;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, fault = 1'b0, oth = 1'b0;
  logic sclr = 1'b0, cfc = 1'b0, rcmd = 1'b0, con = 1'b1;
  logic we, tick, en, lat;
  logic [7:0] wd, rd;
  logic [2:0] att;
  int mismatches = 0, n_compared = 0;
  frr_host_model h (.clk_sys_i(clk_sys_i), .cfg_we_o(we), .cfg_wdata_o(wd),
    .unit_tick_o(tick));
  frr_ctrl DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .cfg_we_i(we),
    .cfg_wdata_i(wd), .cfg_rdata_o(rd), .fault_i(fault),
    .other_shutdown_i(oth), .status_clear_i(sclr), .clear_faults_i(cfc),
    .reset_cmd_i(rcmd), .output_cmd_on_i(con), .unit_tick_i(tick),
    .output_enable_o(en), .fault_latched_o(lat), .attempts_o(att));
  // 40 MHz clock
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic wc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // one compare task per result width
  task automatic chk1(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk3(input string nm, input logic [2:0] e,
    input logic [2:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk8(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one-cycle clear pulse: status bit or clear-faults
  task automatic clr(input logic s);
    if (s) sclr = 1'b1; else cfc = 1'b1;
    wc(1);
    sclr = 1'b0;
    cfc = 1'b0;
    wc(2);
  endtask
  task automatic t_ignore;
    h.wr(8'h00);
    fault = 1'b1;
    wc(20);
    chk1("en", 1'h1, en);
    fault = 1'b0;
  endtask
  task automatic t_hold;
    h.wr(8'hc0);
    fault = 1'b1;
    wc(20);
    chk1("en", 1'h0, en);
    fault = 1'b0;
    wc(3);
    chk1("en", 1'h1, en);
  endtask
  task automatic t_retry1;
    h.wr(8'h88);
    fault = 1'b1;
    wc(2);
    chk1("en", 1'h0, en);
    wc(40);
    chk1("lat", 1'h1, lat);
    chk3("att", 3'h1, att);
    fault = 1'b0;
    clr(1'b0);
    chk1("lat", 1'h0, lat);
    chk3("att", 3'h0, att);
    chk1("en", 1'h1, en);
  endtask
  task automatic t_noretry;
    h.wr(8'h80);
    fault = 1'b1;
    wc(1);
    fault = 1'b0;
    wc(30);
    chk1("en", 1'h0, en);
    clr(1'b1);
    chk1("en", 1'h1, en);
  endtask
  task automatic t_grace;
    h.wr(8'h52);
    chk8("cfg", 8'h52, rd);
    fault = 1'b1;
    wc(8);
    chk1("en", 1'h1, en);
    wc(14);
    chk1("en", 1'h0, en);
    wc(150);
    chk3("att", 3'h2, att);
    chk1("lat", 1'h1, lat);
    fault = 1'b0;
    clr(1'b0);
  endtask
  task automatic t_forever;
    h.wr(8'hb8);
    fault = 1'b1;
    wc(150);
    chk1("lat", 1'h0, lat);
    con = 1'b0;
    wc(3);
    chk1("en", 1'h0, en);
    fault = 1'b0;
    con = 1'b1;
    wc(3);
    chk1("en", 1'h1, en);
  endtask
  // forced shutdown, reset command, shutdown over clear, bias loss
  task automatic t_shutdown;
    oth = 1'b1;
    wc(1);
    oth = 1'b0;
    wc(2);
    chk1("lat", 1'h1, lat);
    chk1("en", 1'h0, en);
    rcmd = 1'b1;
    wc(1);
    rcmd = 1'b0;
    wc(2);
    chk1("lat", 1'h0, lat);
    chk1("en", 1'h1, en);
    oth = 1'b1;
    cfc = 1'b1;
    wc(1);
    oth = 1'b0;
    cfc = 1'b0;
    wc(2);
    chk1("lat", 1'h1, lat);
    arst_n_i = 1'b0;
    wc(2);
    chk1("lat", 1'h0, lat);
    chk8("cfg", 8'h80, rd);
    arst_n_i = 1'b1;
    wc(2);
    chk1("en", 1'h1, en);
    chk3("att", 3'h0, att);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #50000;
    mismatches++;
    end_of_test();
  end
  // main sequence
  initial begin
    wc(8);
    arst_n_i = 1'b1;
    wc(2);
    chk8("cfg", 8'h80, rd);
    t_ignore();
    t_hold();
    t_retry1();
    t_noretry();
    t_grace();
    t_forever();
    t_shutdown();
    end_of_test();
  end
endmodule
`default_nettype wire
